// ---- logic/cjx_core.sv ----
// Execution slice: absolute call/jump, add, add-with-carry and logical AND
`timescale 1ns/10ps
`default_nettype none

module cjx_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Instruction presented by the fetch stage
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  byte2,
    input  wire logic [7:0]  byte3,
    // I/O port: pins in, latch out
    input  wire logic [7:0]  port_pins,
    output logic      [7:0]  port_latch,
    // Architectural state
    output logic      [7:0]  accumulator,
    output logic      [7:0]  status_word,
    output logic      [7:0]  stack_pointer,
    output logic      [15:0] program_counter,
    // Completion
    output logic             done
);
    cjx_pkg::cjx_state_t state_ff, nxt_state;
    logic [7:0]  op_ff, nxt_op, b2_ff, nxt_b2, b3_ff, nxt_b3, opnd_ff, nxt_opnd;
    logic [7:0]  acc_ff, nxt_acc, psw_ff, nxt_psw, sp_ff, nxt_sp, port_ff, nxt_port;
    logic [15:0] pc_ff, nxt_pc;
    logic        done_ff, nxt_done;

    cjx_pkg::cjx_class_t cls;
    cjx_pkg::cjx_src_t   src;
    logic [7:0]  mem_addr, mem_wdata, mem_rdata, fetch_addr, and_other, and_res, add_sum;
    logic        mem_we, dir_is_ram, rmw, add_cin, bit_val;
    logic [15:0] pc_plus2, branch_target, instr_len;
    logic [4:0]  add_lo;
    logic [3:0]  add_mid;
    logic [1:0]  add_hi;

    // Operation class of an opcode; fixed codes win over the 2K-page patterns,
    // since the call pattern overlaps one AND encoding
    function automatic cjx_pkg::cjx_class_t op_class(input logic [7:0] op);
        casez (op)
            cjx_pkg::OPC_AND_DA:   op_class = cjx_pkg::C_AND_DA;
            cjx_pkg::OPC_AND_DI:   op_class = cjx_pkg::C_AND_DI;
            cjx_pkg::OPC_AND_CB:   op_class = cjx_pkg::C_AND_CB;
            cjx_pkg::OPC_AND_CNB:  op_class = cjx_pkg::C_AND_CNB;
            cjx_pkg::OPC_ADD_REG, cjx_pkg::OPC_ADD_IND,
            cjx_pkg::OPC_ADD_DIR, cjx_pkg::OPC_ADD_IMM:   op_class = cjx_pkg::C_ADD;
            cjx_pkg::OPC_ADD_WITH_CARRY_REG, cjx_pkg::OPC_ADD_WITH_CARRY_IND,
            cjx_pkg::OPC_ADD_WITH_CARRY_DIR, cjx_pkg::OPC_ADD_WITH_CARRY_IMM: op_class = cjx_pkg::C_ADD_WITH_CARRY;
            cjx_pkg::OPC_AND_REG, cjx_pkg::OPC_AND_IND,
            cjx_pkg::OPC_AND_DIR, cjx_pkg::OPC_AND_IMM:   op_class = cjx_pkg::C_AND_A;
            cjx_pkg::OPC_CALL:     op_class = cjx_pkg::C_CALL;
            cjx_pkg::OPC_JMP:      op_class = cjx_pkg::C_JMP;
            default:               op_class = cjx_pkg::C_NONE;
        endcase
    endfunction : op_class

    // Source addressing mode of an opcode already known to be in this slice
    function automatic cjx_pkg::cjx_src_t op_src(input logic [7:0] op);
        casez (op)
            cjx_pkg::OPC_ADD_REG, cjx_pkg::OPC_ADD_WITH_CARRY_REG, cjx_pkg::OPC_AND_REG:
                op_src = cjx_pkg::SRC_REG;
            cjx_pkg::OPC_ADD_IND, cjx_pkg::OPC_ADD_WITH_CARRY_IND, cjx_pkg::OPC_AND_IND:
                op_src = cjx_pkg::SRC_IND;
            cjx_pkg::OPC_ADD_IMM, cjx_pkg::OPC_ADD_WITH_CARRY_IMM, cjx_pkg::OPC_AND_IMM:
                op_src = cjx_pkg::SRC_IMM;
            cjx_pkg::OPC_ADD_DIR, cjx_pkg::OPC_ADD_WITH_CARRY_DIR, cjx_pkg::OPC_AND_DIR,
            cjx_pkg::OPC_AND_DA, cjx_pkg::OPC_AND_DI:
                op_src = cjx_pkg::SRC_DIR;
            // bit source is direct bit address only
            cjx_pkg::OPC_AND_CB, cjx_pkg::OPC_AND_CNB:
                op_src = cjx_pkg::SRC_BIT;
            default:
                op_src = cjx_pkg::SRC_NONE;
        endcase
    endfunction : op_src

    // Special register read; a read-modify-write takes the port latch
    function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic latch);
        case (a)
            cjx_pkg::SFR_ACC:  sfr_read = acc_ff;
            cjx_pkg::SFR_PSW:  sfr_read = psw_ff;
            cjx_pkg::SFR_SP:   sfr_read = sp_ff;
            cjx_pkg::SFR_PORT: sfr_read = latch ? port_ff : port_pins;
            default:           sfr_read = 8'h00;
        endcase
    endfunction : sfr_read

    // Decode of the held instruction
    assign cls        = op_class(op_ff);
    assign src        = op_src(op_ff);
    assign dir_is_ram = ~b2_ff[cjx_pkg::DIR_SFR];
    assign rmw        = (cls == cjx_pkg::C_AND_DA) || (cls == cjx_pkg::C_AND_DI);
    assign instr_len  = (src == cjx_pkg::SRC_REG || src == cjx_pkg::SRC_IND ||
                         src == cjx_pkg::SRC_NONE) ? cjx_pkg::LEN_ONE :
                        (cls == cjx_pkg::C_AND_DI) ? cjx_pkg::LEN_THREE : cjx_pkg::LEN_TWO;

    // page target from the advanced counter
    assign pc_plus2      = pc_ff + cjx_pkg::LEN_TWO;
    assign branch_target = {pc_plus2[15:11], op_ff[7:5], b2_ff};

    // nibble-split adder exposes bit 3, bit 6 and bit 7 carries
    assign add_cin = (cls == cjx_pkg::C_ADD_WITH_CARRY) & psw_ff[cjx_pkg::PSW_CY];
    assign add_lo  = {1'b0, acc_ff[3:0]} + {1'b0, opnd_ff[3:0]} + {4'h0, add_cin};
    assign add_mid = {1'b0, acc_ff[6:4]} + {1'b0, opnd_ff[6:4]} + {3'h0, add_lo[4]};
    assign add_hi  = {1'b0, acc_ff[7]} + {1'b0, opnd_ff[7]} + {1'b0, add_mid[3]};
    assign add_sum = {add_hi[0], add_mid[2:0], add_lo[3:0]};

    // byte AND of operand and accumulator or immediate mask
    assign and_other = (cls == cjx_pkg::C_AND_DI) ? b3_ff : acc_ff;
    assign and_res   = opnd_ff & and_other;
    assign bit_val   = opnd_ff[b2_ff[2:0]];

    // RAM address per state; the pointer state re-reads at the fetched pointer
    assign fetch_addr = (src == cjx_pkg::SRC_REG) ? {5'h00, op_ff[2:0]} :
                        (src == cjx_pkg::SRC_IND) ? {7'h00, op_ff[0]} :
                        (src == cjx_pkg::SRC_BIT) ? {cjx_pkg::BIT_BASE, b2_ff[6:3]} : b2_ff;
    // push lands one above the current stack pointer
    assign mem_addr  = (state_ff == cjx_pkg::S_FETCH) ? fetch_addr :
                       (state_ff == cjx_pkg::S_PTR) ? mem_rdata :
                       (cls == cjx_pkg::C_CALL) ? sp_ff + 8'h01 : b2_ff;
    // low byte in the execute cycle, high byte in the push cycle
    assign mem_we    = (state_ff == cjx_pkg::S_PUSH) ||
                       (state_ff == cjx_pkg::S_EXEC &&
                        (cls == cjx_pkg::C_CALL || (rmw && dir_is_ram)));
    assign mem_wdata = (state_ff == cjx_pkg::S_PUSH) ? pc_plus2[15:8] :
                       (cls == cjx_pkg::C_CALL) ? pc_plus2[7:0] : and_res;

    cjx_iram #(
        .DATA_W (8),
        .ADDR_W (8)
    ) u_iram (
        .clk   (clk),
        .addr  (mem_addr),
        .we    (mem_we),
        .wdata (mem_wdata),
        .rdata (mem_rdata)
    );

    // Sequencer: fetch operand, execute, and a second push cycle for calls
    always_comb begin
        nxt_state = state_ff;
        nxt_op    = op_ff;
        nxt_b2    = b2_ff;
        nxt_b3    = b3_ff;
        nxt_opnd  = opnd_ff;
        nxt_acc   = acc_ff;
        nxt_psw   = psw_ff;
        nxt_sp    = sp_ff;
        nxt_pc    = pc_ff;
        nxt_port  = port_ff;
        nxt_done  = 1'b0;
        case (state_ff)
            cjx_pkg::S_IDLE: begin
                if (start) begin
                    nxt_op    = opcode;
                    nxt_b2    = byte2;
                    nxt_b3    = byte3;
                    nxt_state = cjx_pkg::S_FETCH;
                end
            end
            cjx_pkg::S_FETCH: begin
                nxt_state = cjx_pkg::S_EXEC;
                case (src)
                    cjx_pkg::SRC_REG: nxt_state = cjx_pkg::S_OPND;
                    cjx_pkg::SRC_IND: nxt_state = cjx_pkg::S_PTR;
                    cjx_pkg::SRC_IMM: nxt_opnd = b2_ff;
                    cjx_pkg::SRC_DIR: begin
                        if (dir_is_ram) begin
                            nxt_state = cjx_pkg::S_OPND;
                        end else begin
                            nxt_opnd = sfr_read(b2_ff, rmw);
                        end
                    end
                    cjx_pkg::SRC_BIT: begin
                        if (dir_is_ram) begin
                            nxt_state = cjx_pkg::S_OPND;
                        end else begin
                            nxt_opnd = sfr_read({b2_ff[7:3], 3'h0}, 1'b0);
                        end
                    end
                    default: nxt_state = cjx_pkg::S_EXEC;
                endcase
            end
            cjx_pkg::S_PTR: nxt_state = cjx_pkg::S_OPND;
            cjx_pkg::S_OPND: begin
                nxt_opnd  = mem_rdata;
                nxt_state = cjx_pkg::S_EXEC;
            end
            cjx_pkg::S_EXEC: begin
                nxt_state = cjx_pkg::S_IDLE;
                nxt_done  = 1'b1;
                nxt_pc    = pc_ff + instr_len;
                case (cls)
                    cjx_pkg::C_CALL: begin
                        // first push, counter settles after the second
                        nxt_sp    = sp_ff + 8'h01;
                        nxt_pc    = pc_ff;
                        nxt_done  = 1'b0;
                        nxt_state = cjx_pkg::S_PUSH;
                    end
                    // jump stays inside the 2K page
                    cjx_pkg::C_JMP: nxt_pc = branch_target;
                    cjx_pkg::C_ADD, cjx_pkg::C_ADD_WITH_CARRY: begin
                        nxt_acc = add_sum;
                        // carry already folded into the adder
                        nxt_psw[cjx_pkg::PSW_CY] = add_hi[1];
                        nxt_psw[cjx_pkg::PSW_AC] = add_lo[4];
                        // overflow when only one top carry occurs
                        nxt_psw[cjx_pkg::PSW_OV] = add_hi[1] ^ add_mid[3];
                    end
                    cjx_pkg::C_AND_A: nxt_acc = and_res;
                    cjx_pkg::C_AND_DA, cjx_pkg::C_AND_DI: begin
                        // special register destinations; RAM goes by mem_we
                        if (!dir_is_ram) begin
                            case (b2_ff)
                                cjx_pkg::SFR_ACC:  nxt_acc  = and_res;
                                cjx_pkg::SFR_PSW:  nxt_psw  = and_res;
                                cjx_pkg::SFR_SP:   nxt_sp   = and_res;
                                cjx_pkg::SFR_PORT: nxt_port = and_res;
                                default:           nxt_acc  = acc_ff;
                            endcase
                        end
                    end
                    cjx_pkg::C_AND_CB: begin
                        if (!bit_val) begin
                            nxt_psw[cjx_pkg::PSW_CY] = 1'b0;
                        end
                    end
                    // complement used, the bit itself never written
                    cjx_pkg::C_AND_CNB: begin
                        if (bit_val) begin
                            nxt_psw[cjx_pkg::PSW_CY] = 1'b0;
                        end
                    end
                    default: nxt_pc = pc_ff + instr_len;
                endcase
            end
            cjx_pkg::S_PUSH: begin
                // second push and jump to target
                nxt_sp    = sp_ff + 8'h01;
                nxt_pc    = branch_target;
                nxt_done  = 1'b1;
                nxt_state = cjx_pkg::S_IDLE;
            end
            default: nxt_state = cjx_pkg::S_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= cjx_pkg::S_IDLE;
            op_ff    <= 8'h00;
            b2_ff    <= 8'h00;
            b3_ff    <= 8'h00;
            opnd_ff  <= 8'h00;
            acc_ff   <= cjx_pkg::ACC_RST;
            psw_ff   <= cjx_pkg::PSW_RST;
            sp_ff    <= cjx_pkg::SP_RST;
            pc_ff    <= cjx_pkg::PC_RST;
            port_ff  <= cjx_pkg::PORT_RST;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            op_ff    <= nxt_op;
            b2_ff    <= nxt_b2;
            b3_ff    <= nxt_b3;
            opnd_ff  <= nxt_opnd;
            acc_ff   <= nxt_acc;
            psw_ff   <= nxt_psw;
            sp_ff    <= nxt_sp;
            pc_ff    <= nxt_pc;
            port_ff  <= nxt_port;
            done_ff  <= nxt_done;
        end
    end

    // Outputs straight from registers
    assign accumulator     = acc_ff;
    assign status_word     = psw_ff;
    assign stack_pointer   = sp_ff;
    assign program_counter = pc_ff;
    assign port_latch      = port_ff;
    assign done            = done_ff;

    // Reference arithmetic for the checks below
    logic [8:0] chk_sum;
    logic [4:0] chk_nib;
    logic       chk_c7in;
    assign chk_sum  = {1'b0, acc_ff} + {1'b0, opnd_ff} + {8'h00, add_cin};
    assign chk_nib  = {1'b0, acc_ff[3:0]} + {1'b0, opnd_ff[3:0]} + {4'h0, add_cin};
    assign chk_c7in = acc_ff[7] ^ opnd_ff[7] ^ chk_sum[7];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence push_lo_s;
        mem_we && mem_addr == sp_ff + 8'h01 && mem_wdata == pc_plus2[7:0];
    endsequence
    sequence push_hi_s;
        mem_we && mem_addr == sp_ff + 8'h01 && mem_wdata == pc_plus2[15:8];
    endsequence

    call_push_a: assert property (
        (state_ff == cjx_pkg::S_EXEC && cls == cjx_pkg::C_CALL) |->
        push_lo_s ##1 push_hi_s ##1 (sp_ff == $past(sp_ff, 2) + 8'h02))
        else $error("call push order or stack pointer wrong");
    call_target_a: assert property (
        (state_ff == cjx_pkg::S_PUSH) |=> done_ff &&
        pc_ff[10:0] == {$past(op_ff[7:5]), $past(b2_ff)} &&
        pc_ff[15:11] == $past(pc_plus2[15:11]))
        else $error("call target wrong");
    call_flags_a: assert property (
        (state_ff == cjx_pkg::S_EXEC && cls == cjx_pkg::C_CALL) |->
        ##2 psw_ff == $past(psw_ff, 2))
        else $error("call changed flags");
    jump_target_a: assert property (
        (state_ff == cjx_pkg::S_EXEC && cls == cjx_pkg::C_JMP) |=>
        pc_ff == {$past(pc_plus2[15:11]), $past(op_ff[7:5]), $past(b2_ff)})
        else $error("jump target wrong");
    add_result_a: assert property (
        (state_ff == cjx_pkg::S_EXEC &&
         (cls == cjx_pkg::C_ADD || cls == cjx_pkg::C_ADD_WITH_CARRY)) |=>
        acc_ff == $past(chk_sum[7:0]) && done_ff)
        else $error("add result wrong");
    add_carry_a: assert property (
        (state_ff == cjx_pkg::S_EXEC &&
         (cls == cjx_pkg::C_ADD || cls == cjx_pkg::C_ADD_WITH_CARRY)) |=>
        psw_ff[7] == $past(chk_sum[8]) && psw_ff[6] == $past(chk_nib[4]))
        else $error("add carry flags wrong");
    add_ovf_a: assert property (
        (state_ff == cjx_pkg::S_EXEC &&
         (cls == cjx_pkg::C_ADD || cls == cjx_pkg::C_ADD_WITH_CARRY)) |=>
        psw_ff[2] == ($past(chk_c7in) ^ $past(chk_sum[8])))
        else $error("overflow flag wrong");
    and_flags_a: assert property (
        (state_ff == cjx_pkg::S_EXEC && (cls == cjx_pkg::C_AND_A ||
         (rmw && b2_ff != cjx_pkg::SFR_PSW))) |=> $stable(psw_ff))
        else $error("byte AND changed flags");
    and_store_a: assert property (
        (state_ff == cjx_pkg::S_EXEC && rmw && dir_is_ram) |->
        mem_we && mem_addr == b2_ff && mem_wdata == (opnd_ff & and_other))
        else $error("byte AND store to RAM wrong");
    and_latch_a: assert property (
        (state_ff == cjx_pkg::S_FETCH && rmw && b2_ff == cjx_pkg::SFR_PORT) |=>
        ##1 port_ff == ($past(port_ff, 2) & $past(and_other)))
        else $error("port AND not based on latch");
    bit_carry_a: assert property (
        (state_ff == cjx_pkg::S_EXEC && cls == cjx_pkg::C_AND_CB) |=>
        psw_ff[7] == ($past(psw_ff[7]) & $past(bit_val)))
        else $error("bit AND carry wrong");
    nbit_carry_a: assert property (
        (state_ff == cjx_pkg::S_EXEC && cls == cjx_pkg::C_AND_CNB) |=>
        psw_ff[7] == ($past(psw_ff[7]) & ~$past(bit_val)) && !$past(mem_we))
        else $error("complemented bit AND wrong");
endmodule : cjx_core

`default_nettype wire

// ---- logic/cjx_iram.sv ----
// Shared constants and types for the core slice, and its internal data RAM
package cjx_pkg;
    // Reset values of architectural state
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [7:0]  PSW_RST  = 8'h00;
    localparam logic [7:0]  SP_RST   = 8'h07;
    localparam logic [7:0]  PORT_RST = 8'hFF;
    localparam logic [15:0] PC_RST   = 16'h0000;
    // Direct addresses of the special registers this slice owns
    localparam logic [7:0]  SFR_SP   = 8'h81;
    localparam logic [7:0]  SFR_PORT = 8'h90;
    localparam logic [7:0]  SFR_PSW  = 8'hD0;
    localparam logic [7:0]  SFR_ACC  = 8'hE0;
    // Field positions
    localparam int          PSW_CY   = 7;
    localparam int          PSW_AC   = 6;
    localparam int          PSW_OV   = 2;
    localparam int          DIR_SFR  = 7;
    localparam logic [3:0]  BIT_BASE = 4'h2;
    // Instruction lengths in bytes
    localparam logic [15:0] LEN_ONE   = 16'h0001;
    localparam logic [15:0] LEN_TWO   = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;
    // Opcode patterns (question marks are don't-care bits)
    localparam logic [7:0]  OPC_CALL     = 8'b???10010;
    localparam logic [7:0]  OPC_JMP      = 8'b???00001;
    localparam logic [7:0]  OPC_ADD_REG  = 8'b00101???;
    localparam logic [7:0]  OPC_ADD_IND  = 8'b0010011?;
    localparam logic [7:0]  OPC_ADD_DIR  = 8'h25;
    localparam logic [7:0]  OPC_ADD_IMM  = 8'h24;
    localparam logic [7:0]  OPC_ADD_WITH_CARRY_REG = 8'b00111???;
    localparam logic [7:0]  OPC_ADD_WITH_CARRY_IND = 8'b0011011?;
    localparam logic [7:0]  OPC_ADD_WITH_CARRY_DIR = 8'h35;
    localparam logic [7:0]  OPC_ADD_WITH_CARRY_IMM = 8'h34;
    localparam logic [7:0]  OPC_AND_REG  = 8'b01011???;
    localparam logic [7:0]  OPC_AND_IND  = 8'b0101011?;
    localparam logic [7:0]  OPC_AND_DIR  = 8'h55;
    localparam logic [7:0]  OPC_AND_IMM  = 8'h54;
    localparam logic [7:0]  OPC_AND_DA   = 8'h52;
    localparam logic [7:0]  OPC_AND_DI   = 8'h53;
    localparam logic [7:0]  OPC_AND_CB   = 8'h82;
    localparam logic [7:0]  OPC_AND_CNB  = 8'hB0;

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_PTR, S_OPND, S_EXEC, S_PUSH
    } cjx_state_t;

    typedef enum logic [3:0] {
        C_NONE, C_CALL, C_JMP, C_ADD, C_ADD_WITH_CARRY, C_AND_A,
        C_AND_DA, C_AND_DI, C_AND_CB, C_AND_CNB
    } cjx_class_t;

    typedef enum logic [2:0] {
        SRC_NONE, SRC_REG, SRC_IND, SRC_DIR, SRC_IMM, SRC_BIT
    } cjx_src_t;
endpackage : cjx_pkg

`timescale 1ns/10ps
`default_nettype none

module cjx_iram #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 8
) (
    // Clock
    input  wire logic              clk,
    // Access port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              we,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem_ff [2**ADDR_W];

    // The core addresses RAM with a byte, nothing wider or narrower
    if (DATA_W != 8 || ADDR_W != 8) begin : g_bad_size
        $error("cjx_iram supports only 8-bit data and 8-bit addresses");
    end

    // Registered read; a write shows up on a later read of the same cell
    always_ff @(posedge clk) begin
        if (we) begin
            mem_ff[addr] <= wdata;
        end
        rdata <= mem_ff[addr];
    end
endmodule : cjx_iram

`default_nettype wire

// ---- test/tb_cpu_call_jump_add_and_exec.sv ----
// Self-checking bench for the call, jump, add and AND execution slice
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_call_jump_add_and_exec;
    logic        clk, rst, start, done;
    logic [7:0]  opcode, byte2, byte3, port_pins, port_latch;
    logic [7:0]  accumulator, status_word, stack_pointer;
    logic [15:0] program_counter;
    int          err_count, checked;
    logic [31:0] seed;
    logic [47:0] exp_q[$];
    // Bench copy of the architectural state
    logic [7:0]  m_acc, m_psw, m_sp, m_lat, m_ram[256];
    logic [15:0] m_pc;
    logic [7:0]  ops[13] = '{8'h24, 8'h34, 8'h25, 8'h35, 8'h28, 8'h36, 8'h54,
                             8'h52, 8'h53, 8'h82, 8'hB0, 8'h12, 8'h01};

    cjx_core cjx_core_i (.clk(clk), .rst(rst), .start(start), .opcode(opcode),
        .byte2(byte2), .byte3(byte3), .port_pins(port_pins), .port_latch(port_latch),
        .accumulator(accumulator), .status_word(status_word),
        .stack_pointer(stack_pointer), .program_counter(program_counter), .done(done));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] rnd_next(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : rnd_next

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] expv);
        checked++;
        if (seen !== expv) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    task automatic add_acc(input logic [7:0] src, input logic cin);
        logic [8:0] s;
        logic [4:0] l;
        logic [7:0] h;
        s = {1'b0, m_acc} + {1'b0, src} + 9'(cin);
        l = {1'b0, m_acc[3:0]} + {1'b0, src[3:0]} + 5'(cin);
        h = {1'b0, m_acc[6:0]} + {1'b0, src[6:0]} + 8'(cin);
        m_psw[7] = s[8];
        m_psw[6] = l[4];
        m_psw[2] = s[8] ^ h[7];
        m_acc = s[7:0];
    endtask : add_acc

    // Model one instruction, note the result, then drive it until done
    task automatic run_op(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
        logic [7:0]  pins, src;
        logic [15:0] nxt;
        int          n;
        seed = rnd_next(seed);
        pins = seed[7:0];
        nxt = m_pc + 16'h0002;
        src = b2[6] ? m_acc : pins;
        casez (op)
            8'h24, 8'h34: add_acc(b2, op[4] & m_psw[7]);
            8'h25, 8'h35: add_acc(b2[7] ? pins : m_ram[b2], op[4] & m_psw[7]);
            8'h28: begin add_acc(m_ram[0], 1'b0); nxt = m_pc + 16'h0001; end
            8'h36: begin add_acc(m_ram[m_ram[0]], m_psw[7]); nxt = m_pc + 16'h0001; end
            8'h54: m_acc = m_acc & b2;
            8'h52: if (b2 == 8'h90) m_lat &= m_acc; else m_ram[b2] &= m_acc;
            8'h53: begin nxt = m_pc + 16'h0003; if (b2 == 8'h90) m_lat &= b3; else m_ram[b2] &= b3; end
            8'h82, 8'hB0: m_psw[7] = m_psw[7] & (op[5] ^ src[b2[2:0]]);
            8'b???10010: begin
                m_ram[m_sp + 8'h01] = nxt[7:0];
                m_ram[m_sp + 8'h02] = nxt[15:8];
                m_sp = m_sp + 8'h02;
                nxt = {nxt[15:11], op[7:5], b2};
            end
            8'b???00001: nxt = {nxt[15:11], op[7:5], b2};
            default: ;
        endcase
        m_pc = nxt;
        exp_q.push_back({m_acc, m_psw, m_sp, m_lat, m_pc});
        {start, opcode, byte2, byte3, port_pins} <= {1'b1, op, b2, b3, pins};
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 20);
        if (n >= 20) check("done", 48'h0, 48'h1);
    endtask : run_op

    // Each done pulse is matched with the oldest expected state
    always @(posedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) check("spare done", 48'h0, 48'h1);
            else check("state", {accumulator, status_word, stack_pointer, port_latch,
                program_counter}, exp_q.pop_front());
        end
    end

    task automatic final_report();
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report

    // Generous bound; a normal run ends within a few hundred cycles
    initial begin
        #20000;
        err_count++;
        final_report();
    end

    initial begin
        logic [7:0] op, b2;
        {rst, start, opcode, byte2, byte3, port_pins} = {1'b1, 33'h0};
        {err_count, checked, seed} = {32'd0, 32'd0, 32'd24};
        {m_acc, m_psw, m_sp, m_lat, m_pc} = {cjx_pkg::ACC_RST, cjx_pkg::PSW_RST,
            cjx_pkg::SP_RST, cjx_pkg::PORT_RST, cjx_pkg::PC_RST};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("reset", {accumulator, status_word, stack_pointer, port_latch, program_counter,
            7'h0, done}, {m_acc, m_psw, m_sp, m_lat, m_pc, 8'h00});
        // Clear RAM byte 0 so the register and pointer sources are known
        run_op(8'h53, 8'h00, 8'h00);
        run_op(8'h54, 8'h00, 8'h00);
        run_op(8'hF2, 8'h5A, 8'h00);
        run_op(8'h25, m_sp - 8'h01, 8'h00);
        run_op(8'h35, m_sp, 8'h00);
        for (int i = 0; i < 60; i++) begin
            seed = rnd_next(seed);
            op = ops[seed % 13];
            b2 = seed[15:8];
            if (op inside {8'h25, 8'h35, 8'h52, 8'h53}) b2 = 8'h90;
            if (op inside {8'h82, 8'hB0}) b2 = (seed[9] ? 8'hE0 : 8'h90) | {5'h0, seed[2:0]};
            if (op == 8'h12 || op == 8'h01)
                op[7:5] = (seed[26:24] == 3'd2 || seed[26:24] == 3'd4) ? 3'd7 : seed[26:24];
            run_op(op, b2, seed[23:16]);
        end
        final_report();
    end
endmodule : tb_cpu_call_jump_add_and_exec
`default_nettype wire
